// ==== csw_top.v ====
// Purpose: Control and status register with layered write protection, on a 2-wire slave.
// Assumes: 2-wire pins are slow against sys_clk and are synchronised here.
// Notes:   Reset stands for a first power-up; stored bits take their defaults.
`default_nettype none
`include "csw_defs.vh"

module csw_top #(
    parameter STORE_CYCLES  = `CSW_T_STORE_US * `CSW_CLK_MHZ,
    parameter DELAY0_CYCLES = `CSW_T_DELAY0_US * `CSW_CLK_MHZ,
    parameter DELAY1_CYCLES = `CSW_T_DELAY1_US * `CSW_CLK_MHZ,
    parameter DELAY2_CYCLES = `CSW_T_DELAY2_US * `CSW_CLK_MHZ,
    parameter DELAY3_CYCLES = `CSW_T_DELAY3_US * `CSW_CLK_MHZ
) (
    input  wire       sys_clk,
    input  wire       rst_b,
    input  wire       ce,
    input  wire       scl_i,
    input  wire       sda_i,
    output reg        sda_o,
    output reg        sda_oe,
    input  wire       write_protect,
    input  wire       monitor_b_output,
    input  wire       monitor_c_output,
    input  wire       supply_low,
    output reg        global_write_latch,
    output reg        register_write_latch,
    output reg        pot_write_lock,
    output reg  [1:0] delay_select,
    output reg        monitor_b_flag,
    output reg        monitor_c_flag,
    output reg        pot_volatile_write_ok,
    output reg        pot_nonvolatile_write_ok,
    output reg        store_busy,
    output reg        supply_reset_output
);

    localparam TW = `CSW_TIMER_W;

    localparam [8:0] S_IDLE  = 9'h001;
    localparam [8:0] S_ADDR  = 9'h002;
    localparam [8:0] S_SUB   = 9'h004;
    localparam [8:0] S_WDATA = 9'h008;
    localparam [8:0] S_ACK   = 9'h010;
    localparam [8:0] S_RDATA = 9'h020;
    localparam [8:0] S_RACK  = 9'h040;
    localparam [8:0] S_SKIP  = 9'h080;
    localparam [8:0] S_NACK  = 9'h100;

    localparam [1:0] P_NONE   = 2'b00;
    localparam [1:0] P_GLOBAL = 2'b01;
    localparam [1:0] P_REGWR  = 2'b10;
    localparam [1:0] P_FULL   = 2'b11;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and pin edge detection.

    wire [5:0] synced;
    reg        scl_d;
    reg        sda_d;

    csw_sync #(
        .W (6)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .async_in ({supply_low, monitor_c_output, monitor_b_output,
                    write_protect, sda_i, scl_i}),
        .sync_out (synced)
    );

    wire scl_s   = synced[0];
    wire sda_s   = synced[1];
    wire wp_s    = synced[2];
    wire mon_b_s = synced[3];
    wire mon_c_s = synced[4];
    wire low_s   = synced[5];

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Delay selection lookup.

    function [TW-1:0] delay_count;
        input [1:0] sel;
        begin
            if (sel == 2'b00) begin
                delay_count = DELAY0_CYCLES[TW-1:0];
            end else if (sel == 2'b01) begin
                delay_count = DELAY1_CYCLES[TW-1:0];
            end else if (sel == 2'b10) begin
                delay_count = DELAY2_CYCLES[TW-1:0];
            end else begin
                delay_count = DELAY3_CYCLES[TW-1:0];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Store cycle timer and reset release timer.

    reg  store_load;
    wire store_run;
    wire delay_run;

    csw_timer #(
        .W (TW)
    ) u_store (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .load    (store_load),
        .count   (STORE_CYCLES[TW-1:0]),
        .busy    (store_run)
    );

    csw_timer #(
        .W (TW)
    ) u_delay (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .load    (low_s),
        .count   (delay_count(delay_select)),
        .busy    (delay_run)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Serial slave state machine and register.

    reg [8:0] state;
    reg [8:0] after_ack;
    reg [7:0] shreg;
    reg [2:0] bit_cnt;
    reg       byte_done;
    reg       data_seen;
    reg [1:0] pend_kind;
    reg [7:0] pend_data;
    reg [7:0] tx;

    wire [7:0] read_value = {delay_select[1], monitor_b_flag, monitor_c_flag,
                             1'b0, pot_write_lock, register_write_latch,
                             global_write_latch, delay_select[0]};

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            scl_d                <= 1'b1;
            sda_d                <= 1'b1;
            sda_o                <= 1'b0;
            sda_oe               <= 1'b0;
            state                <= S_IDLE;
            after_ack            <= S_IDLE;
            shreg                <= 8'h00;
            bit_cnt              <= 3'h0;
            byte_done            <= 1'b0;
            data_seen            <= 1'b0;
            pend_kind            <= P_NONE;
            pend_data            <= 8'h00;
            tx                   <= 8'h00;
            store_load           <= 1'b0;
            global_write_latch   <= 1'b0;
            register_write_latch <= 1'b0;
            monitor_b_flag       <= 1'b0;
            monitor_c_flag       <= 1'b0;
            pot_write_lock       <= `CSW_RST_LOCK;
            delay_select         <= `CSW_RST_DELAY_SEL;
        end else if (ce) begin
            scl_d      <= scl_s;
            sda_d      <= sda_s;
            store_load <= 1'b0;
            if (!mon_b_s) begin
                monitor_b_flag <= 1'b0;
            end
            if (!mon_c_s) begin
                monitor_c_flag <= 1'b0;
            end
            if (start_ev) begin
                state     <= S_ADDR;
                bit_cnt   <= 3'h0;
                byte_done <= 1'b0;
                data_seen <= 1'b0;
                pend_kind <= P_NONE;
                sda_oe    <= 1'b0;
            end else if (stop_ev) begin
                state  <= S_IDLE;
                sda_oe <= 1'b0;
                if (state == S_WDATA && bit_cnt == 3'h1 &&
                    (!wp_s || pend_kind != P_FULL)) begin
                    case (pend_kind)
                        P_GLOBAL: begin
                            global_write_latch <= pend_data[`CSW_BIT_GLOBAL];
                        end
                        P_REGWR: begin
                            register_write_latch <= 1'b1;
                            global_write_latch   <= pend_data[`CSW_BIT_GLOBAL];
                        end
                        P_FULL: begin
                            global_write_latch   <= pend_data[`CSW_BIT_GLOBAL];
                            register_write_latch <= 1'b0;
                            monitor_b_flag <= pend_data[`CSW_BIT_FLAG_B] & mon_b_s;
                            monitor_c_flag <= pend_data[`CSW_BIT_FLAG_C] & mon_c_s;
                            pot_write_lock <= pend_data[`CSW_BIT_LOCK];
                            delay_select   <= {pend_data[`CSW_BIT_DS_HI],
                                               pend_data[`CSW_BIT_DS_LO]};
                            store_load     <= 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
                pend_kind <= P_NONE;
            end else if (scl_rise) begin
                case (state)
                    S_ADDR, S_SUB, S_WDATA: begin
                        shreg     <= {shreg[6:0], sda_s};
                        bit_cnt   <= bit_cnt + 3'h1;
                        byte_done <= (bit_cnt == 3'h7);
                    end
                    S_RACK: begin
                        state <= S_IDLE;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state)
                    S_ADDR: begin
                        if (byte_done) begin
                            byte_done <= 1'b0;
                            if (store_run) begin
                                state <= S_SKIP;
                            end else if (shreg == `CSW_ADDR_WR) begin
                                sda_oe    <= 1'b1;
                                state     <= S_ACK;
                                after_ack <= S_SUB;
                            end else if (shreg == `CSW_ADDR_RD) begin
                                sda_oe    <= 1'b1;
                                state     <= S_ACK;
                                after_ack <= S_RDATA;
                                tx        <= read_value;
                            end else begin
                                state <= S_SKIP;
                            end
                        end
                    end
                    S_SUB: begin
                        if (byte_done) begin
                            byte_done <= 1'b0;
                            if (shreg == `CSW_REG_OFFSET) begin
                                sda_oe    <= 1'b1;
                                state     <= S_ACK;
                                after_ack <= S_WDATA;
                            end else begin
                                state <= S_SKIP;
                            end
                        end
                    end
                    S_WDATA: begin
                        if (byte_done) begin
                            byte_done <= 1'b0;
                            data_seen <= 1'b1;
                            pend_data <= shreg;
                            if (data_seen) begin
                                pend_kind <= P_NONE;
                                state     <= S_NACK;
                            end else if (shreg == `CSW_SET_GLOBAL ||
                                         shreg == `CSW_CLR_GLOBAL) begin
                                pend_kind <= P_GLOBAL;
                                sda_oe    <= 1'b1;
                                state     <= S_ACK;
                                after_ack <= S_WDATA;
                            end else if (!global_write_latch) begin
                                state <= S_NACK;
                            end else if (shreg[`CSW_BIT_REGWR]) begin
                                pend_kind <= P_REGWR;
                                sda_oe    <= 1'b1;
                                state     <= S_ACK;
                                after_ack <= S_WDATA;
                            end else if (!register_write_latch || wp_s ||
                                         shreg[`CSW_BIT_RSVD]) begin
                                state <= S_NACK;
                            end else begin
                                pend_kind <= P_FULL;
                                sda_oe    <= 1'b1;
                                state     <= S_ACK;
                                after_ack <= S_WDATA;
                            end
                        end
                    end
                    S_ACK: begin
                        bit_cnt <= 3'h0;
                        state   <= after_ack;
                        if (after_ack == S_RDATA) begin
                            sda_oe <= ~tx[7];
                            tx     <= {tx[6:0], 1'b0};
                        end else begin
                            sda_oe <= 1'b0;
                        end
                    end
                    S_RDATA: begin
                        if (bit_cnt == 3'h7) begin
                            sda_oe <= 1'b0;
                            state  <= S_RACK;
                        end else begin
                            sda_oe  <= ~tx[7];
                            tx      <= {tx[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 3'h1;
                        end
                    end
                    S_NACK: begin
                        state <= S_SKIP;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Permission and status outputs.

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            pot_volatile_write_ok    <= 1'b0;
            pot_nonvolatile_write_ok <= 1'b0;
            store_busy               <= 1'b0;
            supply_reset_output      <= 1'b1;
        end else if (ce) begin
            pot_volatile_write_ok    <= global_write_latch & ~pot_write_lock;
            pot_nonvolatile_write_ok <= global_write_latch & ~pot_write_lock & ~wp_s;
            store_busy               <= store_run | store_load;
            supply_reset_output      <= low_s | delay_run;
        end
    end

endmodule // csw_top

`default_nettype wire

// ==== csw_defs.vh ====
// Purpose: Shared constants of the control and status write protection block.
// Assumes: A 125 MHz system clock.
// Notes:   Times are in microseconds; cycle counts derive from them.
`ifndef CSW_DEFS_VH
`define CSW_DEFS_VH

`define CSW_CLK_MHZ        125
`define CSW_T_STORE_US     5000
`define CSW_T_DELAY0_US    50000
`define CSW_T_DELAY1_US    100000
`define CSW_T_DELAY2_US    200000
`define CSW_T_DELAY3_US    300000

`define CSW_ADDR_WR        8'ha4
`define CSW_ADDR_RD        8'ha5
`define CSW_REG_OFFSET     8'hff
`define CSW_SET_GLOBAL     8'h02
`define CSW_CLR_GLOBAL     8'h00

`define CSW_BIT_DS_LO      0
`define CSW_BIT_GLOBAL     1
`define CSW_BIT_REGWR      2
`define CSW_BIT_LOCK       3
`define CSW_BIT_RSVD       4
`define CSW_BIT_FLAG_C     5
`define CSW_BIT_FLAG_B     6
`define CSW_BIT_DS_HI      7

`define CSW_RST_DELAY_SEL  2'b01
`define CSW_RST_LOCK       1'b0

`define CSW_TIMER_W        26

`endif

// ==== csw_sync.v ====
// Purpose: Two flip-flop synchroniser for inputs from outside the clock domain.
// Assumes: Inputs are levels that stay put for several clock periods.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module csw_sync #(
    parameter W = 1
) (
    input  wire         sys_clk,
    input  wire         rst_b,
    input  wire         ce,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] stage1;

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            stage1   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else if (ce) begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // csw_sync

`default_nettype wire

// ==== csw_timer.v ====
// Purpose: Down counter that stays busy for a loaded number of cycles.
// Assumes: Count is at least one.
// Notes:   A load while busy restarts the count.
`default_nettype none

module csw_timer #(
    parameter W = 26
) (
    input  wire         sys_clk,
    input  wire         rst_b,
    input  wire         ce,
    input  wire         load,
    input  wire [W-1:0] count,
    output reg          busy
);

    reg [W-1:0] remain;

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            remain <= {W{1'b0}};
            busy   <= 1'b0;
        end else if (ce) begin
            if (load) begin
                remain <= count;
                busy   <= 1'b1;
            end else if (remain > {{(W-1){1'b0}}, 1'b1}) begin
                remain <= remain - {{(W-1){1'b0}}, 1'b1};
            end else begin
                remain <= {W{1'b0}};
                busy   <= 1'b0;
            end
        end
    end

endmodule // csw_timer

`default_nettype wire

// ==== csw_master.sv ====
// Purpose: 2-wire bus master model that frames register accesses.
// Assumes: SDA is open drain with a pull-up; SCL idles high between frames.
// Notes:   A bit lasts 64 ns, with edges placed off the sys_clk grid.
`default_nettype none
`include "csw_defs.vh"

module csw_master (
    output var logic scl,
    output var logic sda_pull,
    input  wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic bit_cyc(input logic pull, output logic seen);
        sda_pull = pull;
        #16.3 scl = 1'b1;
        #28.1 seen = sda_line;
        #3.9 scl = 1'b0;
        #15.7;
    endtask

    task automatic start();
        sda_pull = 1'b0;
        #16.3 scl = 1'b1;
        #16.1 sda_pull = 1'b1;
        #16.2 scl = 1'b0;
        #16.3;
    endtask

    task automatic stop();
        sda_pull = 1'b1;
        #16.3 scl = 1'b1;
        #16.1 sda_pull = 1'b0;
        #32;
    endtask

    task automatic send(input logic [7:0] b, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cyc(~b[i], s);
        bit_cyc(1'b0, nack);
    endtask

    task automatic recv(output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b0, s);
            b[i] = s;
        end
        bit_cyc(1'b0, s);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Write frame: address, offset, one data byte or two, then stop.
    task automatic wr(input logic [7:0] d, input logic two, output logic [1:0] nk);
        logic n;
        start();
        send(`CSW_ADDR_WR, nk[1]);
        send(`CSW_REG_OFFSET, n);
        send(d, nk[0]);
        if (two) send(d, nk[0]);
        stop();
    endtask

    // Read frame: offset set by a write, repeated start, one byte, no ack.
    task automatic rd(output logic [7:0] d);
        logic n;
        start();
        send(`CSW_ADDR_WR, n);
        send(`CSW_REG_OFFSET, n);
        start();
        send(`CSW_ADDR_RD, n);
        recv(d);
        stop();
    endtask
endmodule // csw_master
`default_nettype wire

// ==== csw_top_chk.sv ====
// Purpose: Concurrent checks on the ports of the control and status block.
// Assumes: The clock enable is held high while the checks run.
// Notes:   Bound to csw_top from the bench.
`default_nettype none

module csw_top_chk #(
    parameter int STORE_CYCLES = 625000
) (
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic       sda_oe,
    input wire logic       write_protect,
    input wire logic       monitor_b_output,
    input wire logic       monitor_c_output,
    input wire logic       global_write_latch,
    input wire logic       register_write_latch,
    input wire logic       pot_write_lock,
    input wire logic [1:0] delay_select,
    input wire logic       monitor_b_flag,
    input wire logic       monitor_c_flag,
    input wire logic       pot_volatile_write_ok,
    input wire logic       pot_nonvolatile_write_ok,
    input wire logic       store_busy
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] busy_len;
    always_ff @(posedge sys_clk) busy_len <= store_busy ? busy_len + 32'd1 : 32'd0;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_wp_held;
        write_protect [*5];
    endsequence
    sequence s_mon_b_low;
        !monitor_b_output [*5];
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    a_store_needs_global: assert property ($rose(store_busy) |-> global_write_latch)
        else $error("store began with the global latch clear");
    a_store_length: assert property ($fell(store_busy) |->
        busy_len >= STORE_CYCLES - 1 && busy_len <= STORE_CYCLES + 1)
        else $error("store cycle length wrong");
    a_store_clears_reg: assert property ($rose(store_busy) |-> ##[0:4] !register_write_latch)
        else $error("register latch kept after store start");
    a_reg_needs_global: assert property ($rose(register_write_latch) |-> $past(global_write_latch))
        else $error("register latch set without global latch");
    a_lock_blocks_vol: assert property (pot_write_lock |=> !pot_volatile_write_ok)
        else $error("wiper write allowed under lock");
    a_vol_needs_global: assert property (pot_volatile_write_ok |-> $past(global_write_latch))
        else $error("wiper write allowed with global latch clear");
    a_wp_blocks_nv: assert property (s_wp_held |-> !pot_nonvolatile_write_ok)
        else $error("stored wiper write allowed under protect");
    a_wp_freezes_nv: assert property (s_wp_held |=> $stable(pot_write_lock) && $stable(delay_select))
        else $error("stored bits changed under protect");
    a_flag_b_clear: assert property (s_mon_b_low |-> !monitor_b_flag)
        else $error("flag b held with monitor b low");
    a_flag_c_clear: assert property (!monitor_c_output [*5] |-> !monitor_c_flag)
        else $error("flag c held with monitor c low");
    a_busy_no_ack: assert property (store_busy [*8] |-> !sda_oe)
        else $error("bus answered during store");
endmodule // csw_top_chk
`default_nettype wire

// ==== csw_top_bench.sv ====
// Purpose: Self-checking bench for the control and status register block.
// Assumes: Store and release delay counts are shortened by parameter.
// Notes:   The checker is bound to the top module after this module.
`default_nettype none
`include "csw_defs.vh"

module csw_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int STORE = 400;
    localparam int DLY [4] = '{20, 40, 80, 120};

    logic       sys_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       write_protect = 1'b0;
    logic       monitor_b_output = 1'b1;
    logic       monitor_c_output = 1'b0;
    logic       supply_low = 1'b0;
    logic       scl, sda_pull, sda_o, sda_oe, store_busy, supply_reset_output;
    logic       global_write_latch, register_write_latch, pot_write_lock;
    logic       monitor_b_flag, monitor_c_flag;
    logic       pot_volatile_write_ok, pot_nonvolatile_write_ok;
    logic [1:0] delay_select;
    logic [1:0] nk;
    logic [7:0] rd_byte;
    int         cnt;
    int         mismatches = 0;
    int         num_checks = 0;
    wire        sda_line = ~(sda_pull | (sda_oe & ~sda_o));

    csw_master u_csw_master (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

    csw_top #(
        .STORE_CYCLES (STORE),
        .DELAY0_CYCLES(DLY[0]),
        .DELAY1_CYCLES(DLY[1]),
        .DELAY2_CYCLES(DLY[2]),
        .DELAY3_CYCLES(DLY[3])
    ) u_csw_top (
        .sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .write_protect(write_protect),
        .monitor_b_output(monitor_b_output), .monitor_c_output(monitor_c_output),
        .supply_low(supply_low), .global_write_latch(global_write_latch),
        .register_write_latch(register_write_latch), .pot_write_lock(pot_write_lock),
        .delay_select(delay_select), .monitor_b_flag(monitor_b_flag),
        .monitor_c_flag(monitor_c_flag), .pot_volatile_write_ok(pot_volatile_write_ok),
        .pot_nonvolatile_write_ok(pot_nonvolatile_write_ok), .store_busy(store_busy),
        .supply_reset_output(supply_reset_output)
    );

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] d, input logic two);
        u_csw_master.wr(d, two, nk);
        tick(10);
    endtask
    task automatic rd();
        u_csw_master.rd(rd_byte);
        tick(10);
    endtask
    task automatic nv_write(input logic [7:0] v);
        wr(`CSW_SET_GLOBAL, 1'b0);
        wr(8'h06, 1'b0);
        wr(v, 1'b0);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 600 && store_busy !== 1'b0; i++) tick(1);
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(2);
        rst_b = 1'b1;
        tick(1);
        chk_byte({global_write_latch, register_write_latch, pot_write_lock, monitor_b_flag,
                  monitor_c_flag, store_busy, delay_select}, 8'h01);
        rd();
        chk_byte(rd_byte, 8'h01);
        wr(8'h06, 1'b0);
        chk_byte({nk, register_write_latch, global_write_latch, 4'h0}, 8'h40);
        wr(`CSW_SET_GLOBAL, 1'b0);
        chk_byte({nk, global_write_latch, store_busy, pot_volatile_write_ok, 3'h0}, 8'h28);
        wr(8'h06, 1'b0);
        rd();
        chk_byte(rd_byte, 8'h07);
        write_protect = 1'b1;
        tick(6);
        chk_byte({6'h00, pot_volatile_write_ok, pot_nonvolatile_write_ok}, 8'h02);
        wr(8'h4a, 1'b0);
        chk_byte({nk, store_busy, pot_write_lock, monitor_b_flag, 3'h0}, 8'h40);
        write_protect = 1'b0;
        nv_write(8'hea);
        chk_byte({store_busy, register_write_latch, 6'h00}, 8'h80);
        wr(`CSW_SET_GLOBAL, 1'b0);
        chk_bit(nk[1], 1'b1);
        wait_idle();
        rd();
        chk_byte(rd_byte, 8'hca);
        chk_bit(pot_volatile_write_ok, 1'b0);
        monitor_b_output = 1'b0;
        tick(6);
        chk_bit(monitor_b_flag, 1'b0);
        wr(8'h06, 1'b0);
        wr(8'h07, 1'b0);
        rd();
        chk_byte(rd_byte, 8'h8e);
        wr(8'h03, 1'b1);
        chk_byte({nk, store_busy, pot_write_lock, 4'h0}, 8'h50);
        monitor_c_output = 1'b1;
        for (int c = 0; c < 4; c++) begin
            nv_write({c[1], 6'b010001, c[0]});
            wait_idle();
            chk_byte({pot_write_lock, monitor_c_flag, 4'h0, delay_select}, 8'(c + 64));
            supply_low = 1'b1;
            tick(4);
            chk_bit(supply_reset_output, 1'b1);
            supply_low = 1'b0;
            cnt = 0;
            while (supply_reset_output !== 1'b0 && cnt < 200) begin
                tick(1);
                cnt++;
            end
            chk_bit(cnt >= DLY[c] && cnt <= DLY[c] + 6, 1'b1);
        end
        monitor_c_output = 1'b0;
        tick(6);
        chk_bit(monitor_c_flag, 1'b0);
        wr(`CSW_CLR_GLOBAL, 1'b0);
        chk_byte({nk, global_write_latch, pot_volatile_write_ok, 4'h0}, 8'h00);
        tally_and_finish();
    end

    initial begin
        #200us;
        mismatches++;
        tally_and_finish();
    end
endmodule // csw_top_bench

bind csw_top csw_top_chk #(.STORE_CYCLES(STORE_CYCLES)) u_csw_top_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .sda_oe(sda_oe), .write_protect(write_protect),
    .monitor_b_output(monitor_b_output), .monitor_c_output(monitor_c_output),
    .global_write_latch(global_write_latch), .register_write_latch(register_write_latch),
    .pot_write_lock(pot_write_lock), .delay_select(delay_select),
    .monitor_b_flag(monitor_b_flag), .monitor_c_flag(monitor_c_flag),
    .pot_volatile_write_ok(pot_volatile_write_ok),
    .pot_nonvolatile_write_ok(pot_nonvolatile_write_ok), .store_busy(store_busy)
);
`default_nettype wire
